// >>> src/tcw_defines.vh
// Constants of the timer compare waveform block.
// How it works
// R1 - Capture codes 110/111 use comparator A/B events.
// R2 - Compare codes: flag only, set, clear, toggle.
// R3 - Codes 100/101 give PWM; count mode picks alignment.
// R4 - One control window reaches only the indexed channel.
// R5 - Mode bit 1 compares, 0 captures.
// R6 - Match when all 16 value bits equal timer.
// R7 - Match sets flag; clear bit zeroes timer.
// R8 - Each channel owns one output pin.
// R9 - Pin actions ignore interrupt enables.
// R10 - Software readies the port pin beforehand.
// R11 - Reset sets every output state high.
// R12 - DAC enabled: channels C, D leave pins.
// R13 - External memory: no channel drives pins.
// R14 - Software may rewrite values for extra matches.
// R15 - Normal mode period follows the top value.
// R16 - Clear-on-match makes value set the interval.
// R17 - Dual-slope acts on up and down counts.
// R18 - Flag interrupts need channel and global enables.
// R19 - Software keeps clear bits off for baud use.
// R20 - Dual-slope events record count direction.
// R21 - One action per match, not while held.
// R22 - Code 000 leaves output state unchanged.
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH

// Register byte offsets.
`define TCW_ADDR_CTRL 8'h00
`define TCW_ADDR_INDEX 8'h04
`define TCW_ADDR_WINDOW 8'h08
`define TCW_ADDR_FLAGS 8'h0c
`define TCW_ADDR_VALUE_LOW 8'h10
`define TCW_ADDR_VALUE_HIGH 8'h14
`define TCW_ADDR_PINS 8'h18

// Block control register fields.
`define TCW_CTRL_IRQ_ALL 0
`define TCW_CTRL_DAC 1
`define TCW_CTRL_EXT_MEM 2

// Channel control window fields.
`define TCW_CH_IRQ_EN 7
`define TCW_CH_DIR 6
`define TCW_CH_CLR 4
`define TCW_CH_MODE 3

// Reset values.
`define TCW_CTRL_RST 8'h00
`define TCW_CH_CTRL_RST 8'h00
`define TCW_VALUE_RST 16'h0000
`define TCW_OUT_RST 1'b1

// Channel action codes.
`define TCW_ACT_NONE 3'h0
`define TCW_ACT_SET 3'h1
`define TCW_ACT_CLEAR 3'h2
`define TCW_ACT_TOGGLE 3'h3
`define TCW_ACT_PWM_INV 3'h4
`define TCW_ACT_PWM_NONINV 3'h5
`define TCW_ACT_CAP_A 3'h6
`define TCW_ACT_CAP_B 3'h7

// Count mode bit that selects dual-slope counting.
`define TCW_CM_DUAL 1

`endif

// >>> src/tcw_match.v
// Match detector that fires once on entry into equality.
`timescale 1ns/10ps
module tcw_match (
    input wire pclk,
    input wire presetn,
    input wire [15:0] timer_count,
    input wire [15:0] compare_value,
    output wire match_pulse
);

    // Full 16-bit equality of timer and channel value.
    wire equal = (timer_count == compare_value); // R6

    // Equality seen on the previous edge.
    reg prev_equal;

    // ----------------------------------------
    // Equality history
    // ----------------------------------------
    // A held count must not repeat the action, so only a new equality
    // counts; a rewrite of the value onto the held count still fires.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_equal <= 1'b0;
        end else begin
            prev_equal <= equal;
        end
    end

    assign match_pulse = equal & ~prev_equal; // R21

endmodule

// >>> src/tcw_action.v
// Next output state of one channel from its action code.
`timescale 1ns/10ps
`include "tcw_defines.vh"
module tcw_action (
    input wire [2:0] action,
    input wire compare_mode,
    input wire match,
    input wire dual_slope,
    input wire counting_down,
    input wire at_bottom,
    input wire current_out,
    output reg next_out
);

    // ----------------------------------------
    // Action decode
    // ----------------------------------------
    // In edge-aligned PWM a match and the bottom may coincide; the match
    // wins so that a value of zero holds the output steady.
    always @* begin
        next_out = current_out;
        if (compare_mode) begin // R5
            case (action)
                `TCW_ACT_NONE: begin
                    next_out = current_out; // R22
                end
                `TCW_ACT_SET: begin
                    if (match) next_out = 1'b1; // R2
                end
                `TCW_ACT_CLEAR: begin
                    if (match) next_out = 1'b0; // R2
                end
                `TCW_ACT_TOGGLE: begin
                    if (match) next_out = ~current_out; // R2
                end
                `TCW_ACT_PWM_INV: begin
                    if (dual_slope) begin
                        // Set going up, clear coming down.
                        if (match) next_out = ~counting_down; // R3 R17
                    end else if (match) begin
                        next_out = 1'b0; // R3
                    end else if (at_bottom) begin
                        next_out = 1'b1; // R15
                    end
                end
                `TCW_ACT_PWM_NONINV: begin
                    if (dual_slope) begin
                        // Clear going up, set coming down.
                        if (match) next_out = counting_down; // R3 R17
                    end else if (match) begin
                        next_out = 1'b1; // R3
                    end else if (at_bottom) begin
                        next_out = 1'b0; // R15
                    end
                end
                default: begin
                    // Reserved codes leave the output alone.
                    next_out = current_out; // R2
                end
            endcase
        end
    end

endmodule

// >>> src/tcw_top.v
// Four-channel compare/capture array with APB register access.
`timescale 1ns/10ps
`include "tcw_defines.vh"
module tcw_top (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire [15:0] timer_count,
    input wire timer_count_down,
    input wire timer_at_bottom,
    input wire [1:0] count_mode_select,
    input wire capture_reload_select,
    input wire comparator_a_event,
    input wire comparator_b_event,
    output reg timer_clear,
    output reg [3:0] compare_out,
    output reg [3:0] compare_out_oe,
    output wire irq_request
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // Setup phase of a transfer: the read data is prepared here.
    wire bus_setup = psel & ~penable;

    // Access phase: the slave always answers in this cycle.
    wire bus_access = psel & penable;

    // Write strobe, one cycle, at the completing edge.
    wire bus_write = bus_access & pwrite;

    // Per-register write strobes.
    wire wr_ctrl = bus_write & (paddr == `TCW_ADDR_CTRL);
    wire wr_index = bus_write & (paddr == `TCW_ADDR_INDEX);
    wire wr_window = bus_write & (paddr == `TCW_ADDR_WINDOW);
    wire wr_flags = bus_write & (paddr == `TCW_ADDR_FLAGS);
    wire wr_low = bus_write & (paddr == `TCW_ADDR_VALUE_LOW);
    wire wr_high = bus_write & (paddr == `TCW_ADDR_VALUE_HIGH);

    // Address hits any mapped register.
    wire addr_mapped = (paddr == `TCW_ADDR_CTRL) |
                       (paddr == `TCW_ADDR_INDEX) |
                       (paddr == `TCW_ADDR_WINDOW) |
                       (paddr == `TCW_ADDR_FLAGS) |
                       (paddr == `TCW_ADDR_VALUE_LOW) |
                       (paddr == `TCW_ADDR_VALUE_HIGH) |
                       (paddr == `TCW_ADDR_PINS);

    // No wait states are ever inserted.
    assign pready = 1'b1;

    // ----------------------------------------
    // Block-wide registers
    // ----------------------------------------

    // Global interrupt enable, DAC enable and external memory use.
    reg [7:0] block_ctrl;

    // Channel chosen for the window and value registers.
    reg [1:0] channel_index_select;

    // Sticky match flags, one per channel.
    reg [3:0] channel_flag_register;

    // Aliases of the block control bits.
    wire irq_all_enable = block_ctrl[`TCW_CTRL_IRQ_ALL];
    wire dac_enable = block_ctrl[`TCW_CTRL_DAC];
    wire ext_mem_enable = block_ctrl[`TCW_CTRL_EXT_MEM];

    // Dual-slope counting applies only in auto-reload operation.
    wire dual_slope = count_mode_select[`TCW_CM_DUAL] &
                      ~capture_reload_select;

    // Block control and index register writes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_ctrl <= `TCW_CTRL_RST;
            channel_index_select <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                block_ctrl <= {5'h00, pwdata[2:0]};
            end
            if (wr_index) begin
                channel_index_select <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // Per-channel logic
    // ----------------------------------------

    // Control window contents of all channels, eight bits each.
    wire [31:0] ctrl_all;

    // Data values of all channels, sixteen bits each.
    wire [63:0] value_all;

    // One-cycle event of each channel, compare or capture.
    wire [3:0] channel_event;

    // Event asks for the timebase to be cleared.
    wire [3:0] clear_request;

    // Next output state of each channel.
    wire [3:0] next_out;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_channel
            // This channel is the one the window points at.
            wire selected = (channel_index_select == i[1:0]); // R4

            // Control register: enables, mode, action code.
            reg [7:0] ctrl;

            // Data register, compared or loaded by a capture.
            reg [15:0] value;

            // Decoded control fields.
            wire [2:0] action = ctrl[2:0];
            wire compare_mode = ctrl[`TCW_CH_MODE]; // R5

            // Entry into equality with the timer.
            wire match;

            tcw_match u_match (
                .pclk(pclk),
                .presetn(presetn),
                .timer_count(timer_count),
                .compare_value(value),
                .match_pulse(match)
            );

            // Capture trigger from either analog comparator.
            wire capture = ~compare_mode & (
                ((action == `TCW_ACT_CAP_A) & comparator_a_event) |
                ((action == `TCW_ACT_CAP_B) & comparator_b_event)); // R1

            // A compare match or a capture is the channel event.
            assign channel_event[i] = compare_mode ? match : capture;

            // Clear the timebase when this channel asks for it.
            assign clear_request[i] =
                channel_event[i] & ctrl[`TCW_CH_CLR]; // R7 R16

            // Export the registers for the read multiplexer.
            assign ctrl_all[8*i +: 8] = ctrl;
            assign value_all[16*i +: 16] = value;

            // Output action decode of this channel.
            tcw_action u_action (
                .action(action),
                .compare_mode(compare_mode),
                .match(match),
                .dual_slope(dual_slope),
                .counting_down(timer_count_down),
                .at_bottom(timer_at_bottom),
                .current_out(compare_out[i]),
                .next_out(next_out[i])
            );

            // Control register. The direction bit is written by the
            // hardware only; software writes to it are dropped.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl <= `TCW_CH_CTRL_RST;
                end else begin
                    if (wr_window & selected) begin // R4
                        ctrl[7] <= pwdata[7];
                        ctrl[5:0] <= pwdata[5:0];
                    end
                    if (channel_event[i] & dual_slope) begin
                        ctrl[`TCW_CH_DIR] <= timer_count_down; // R20
                    end
                end
            end

            // Data register. A capture in the same cycle as a software
            // write wins, so the captured time is never lost.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    value <= `TCW_VALUE_RST;
                end else if (capture) begin
                    value <= timer_count; // R1
                end else begin
                    if (wr_low & selected) begin
                        value[7:0] <= pwdata[7:0];
                    end
                    if (wr_high & selected) begin
                        value[15:8] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Match flags and interrupt request
    // ----------------------------------------

    // Flags clear by writing one; an event in the same cycle wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_flag_register <= 4'h0;
        end else begin
            channel_flag_register <= (channel_flag_register &
                ~(wr_flags ? pwdata[3:0] : 4'h0)) |
                channel_event; // R7
        end
    end

    // Channel interrupt enables gathered from the control registers.
    wire [3:0] channel_irq_enable = {ctrl_all[8*3 + `TCW_CH_IRQ_EN],
                                     ctrl_all[8*2 + `TCW_CH_IRQ_EN],
                                     ctrl_all[8*1 + `TCW_CH_IRQ_EN],
                                     ctrl_all[`TCW_CH_IRQ_EN]};

    // A flag requests service only with both enables set.
    assign irq_request = irq_all_enable &
        (|(channel_flag_register & channel_irq_enable)); // R18

    // ----------------------------------------
    // Timebase clear
    // ----------------------------------------

    // Registered so the timebase sees a clean one-cycle pulse.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_clear <= 1'b0;
        end else begin
            timer_clear <= |clear_request; // R7
        end
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------

    // Output states follow the action decode whatever the interrupt
    // enables say; they start high out of reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out <= {4{`TCW_OUT_RST}}; // R11
        end else begin
            compare_out <= next_out; // R8 R9
        end
    end

    // Pin drive enables. The state keeps updating while the pin is
    // taken away, so it resumes consistently when handed back.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out_oe <= 4'h0;
        end else if (ext_mem_enable) begin
            compare_out_oe <= 4'h0; // R13
        end else if (dac_enable) begin
            compare_out_oe <= 4'h3; // R12
        end else begin
            compare_out_oe <= 4'hf; // R8
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------

    // Selected channel's registers for the windowed reads.
    wire [7:0] window_read = ctrl_all[8*channel_index_select +: 8]; // R4
    wire [15:0] value_read = value_all[16*channel_index_select +: 16];

    // Read value of the addressed register.
    reg [31:0] next_prdata;

    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `TCW_ADDR_CTRL: begin
                next_prdata = {24'h000000, block_ctrl};
            end
            `TCW_ADDR_INDEX: begin
                next_prdata = {30'h00000000, channel_index_select};
            end
            `TCW_ADDR_WINDOW: begin
                next_prdata = {24'h000000, window_read};
            end
            `TCW_ADDR_FLAGS: begin
                next_prdata = {28'h0000000, channel_flag_register};
            end
            `TCW_ADDR_VALUE_LOW: begin
                next_prdata = {24'h000000, value_read[7:0]};
            end
            `TCW_ADDR_VALUE_HIGH: begin
                next_prdata = {24'h000000, value_read[15:8]};
            end
            `TCW_ADDR_PINS: begin
                next_prdata = {24'h000000, compare_out_oe, compare_out};
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    // Read data and error are captured in the setup cycle and stand
    // through the access cycle, which always completes at once.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (bus_setup) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= ~addr_mapped;
        end
    end

endmodule

// >>> testbench/tcw_chk.sv
// Port-level concurrent checks for the compare array.
`timescale 1ns/10ps
module tcw_chk (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [15:0] timer_count,
    input wire timer_at_bottom,
    input wire comparator_a_event,
    input wire comparator_b_event,
    input wire timer_clear,
    input wire [3:0] compare_out,
    input wire [3:0] compare_out_oe,
    input wire irq_request
);
    // ------------------------
    // Helper state
    // ------------------------
    reg [2:0] ctrl_copy; // Block control as last written over the bus.
    reg [3:0] quiet; // Cycles with no count, bus, bottom or capture news.
    wire acc = psel && penable; // Access phase of a transfer.

    // Tracks control writes and counts calm cycles in which nothing may
    // start a new match.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_copy <= 3'h0;
            quiet <= 4'h0;
        end else begin
            if (acc && pwrite && paddr == 8'h00) begin
                ctrl_copy <= pwdata[2:0];
            end
            if (psel || timer_at_bottom || $changed(timer_count) ||
                comparator_a_event || comparator_b_event) begin
                quiet <= 4'h0;
            end else if (quiet != 4'hf) begin
                quiet <= quiet + 4'h1;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------
    // Assertions
    // ------------------------
    reset_out_high_a: assert property ($rose(presetn) |->
        compare_out == 4'hf) else $error("outputs not high after reset");
    clear_one_pulse_a: assert property (timer_clear |=>
        !timer_clear) else $error("timer clear longer than one cycle");
    irq_global_gate_a: assert property (irq_request |->
        ctrl_copy[0]) else $error("interrupt without global enable");
    ext_mem_off_a: assert property (ctrl_copy[2] && $past(ctrl_copy[2])
        |-> compare_out_oe == 4'h0) else $error("pin driven in ext mode");
    dac_off_a: assert property (ctrl_copy[1] && $past(ctrl_copy[1])
        |-> compare_out_oe[3:2] == 2'b00) else $error("C or D driven");
    oe_normal_a: assert property ($past(presetn) && ctrl_copy[2:1] == 0
        && $past(ctrl_copy[2:1]) == 0 |-> compare_out_oe == 4'hf)
        else $error("pin drive missing");
    slverr_map_a: assert property (acc && paddr[1:0] == 2'b00 |->
        pslverr == (paddr > 8'h18)) else $error("wrong slave error");
    write_rdata_a: assert property (acc && pwrite |->
        prdata == 32'h0) else $error("read data not zero on write");
    quiet_hold_a: assert property (quiet >= 4'h4 |->
        $stable(compare_out) && !timer_clear) else $error("repeat action");

    cover property (timer_clear);
    cover property (irq_request);
    cover property (acc && pslverr);
endmodule

// >>> testbench/tcw_pin_model.sv
// Port pins behind the compare outputs, pulled up when undriven.
`timescale 1ns/10ps
module tcw_pin_model (
    input wire [3:0] compare_out,
    input wire [3:0] compare_out_oe,
    input wire [3:0] port_drive_en,
    output wire [3:0] pin_level
);
    wire [3:0] driven = compare_out_oe & port_drive_en; // Pin in output mode.

    // An undriven pin floats to its pull-up level.
    assign pin_level = (compare_out & driven) | ~driven;
endmodule

// >>> testbench/timer_compare_waveform_tb.sv
// Self-checking bench for the compare array.
`timescale 1ns/10ps
`include "tcw_defines.vh"
module timer_compare_waveform_tb;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    reg pwrite = 1'b0, timer_count_down = 1'b0, timer_at_bottom = 1'b0;
    reg capture_reload_select = 1'b0;
    reg comparator_a_event = 1'b0, comparator_b_event = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [15:0] timer_count = 16'hffff;
    reg [1:0] count_mode_select = 2'b01;
    reg [3:0] port_drive_en = 4'h0; // Software port mode per pin.
    wire [31:0] prdata;
    wire pready, pslverr, timer_clear, irq_request;
    wire [3:0] compare_out, compare_out_oe, pin_level;
    integer mismatches = 0, samples_checked = 0, i, n;
    reg [31:0] rd; // Data of the last read.
    reg [3:0] rows [0:8]; // Action code beside the output it must give.
    reg dir; // Count direction of a dual-slope step.

    always #5 pclk = ~pclk;

    tcw_top u_tcw_top (.*);
    tcw_pin_model u_tcw_pin_model (.*);

    // ------------------------
    // Tasks
    // ------------------------
    // Compares a seen value with the expected one and counts both.
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task close_out;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked,
                mismatches);
            if (mismatches == 0 && samples_checked > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    // One APB transfer, entered just after a rising edge.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 20) begin
                @(posedge pclk);
                k = k + 1;
            end
            if (k >= 20) begin
                mismatches = mismatches + 1;
                close_out;
            end
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Reads a register and compares it.
    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check(rd, exp);
        end
    endtask

    // Selects a channel and sets its control and compare value.
    task setch(input [1:0] ch, input [7:0] win, input [15:0] v);
        begin
            apb(1'b1, `TCW_ADDR_INDEX, {30'h0, ch});
            apb(1'b1, `TCW_ADDR_WINDOW, {24'h0, win});
            apb(1'b1, `TCW_ADDR_VALUE_LOW, {24'h0, v[7:0]});
            apb(1'b1, `TCW_ADDR_VALUE_HIGH, {24'h0, v[15:8]});
        end
    endtask

    // Moves the timebase off a value and then onto it.
    task hit(input [15:0] v);
        begin
            timer_count <= ~v;
            repeat (2) @(posedge pclk);
            timer_count <= v;
            repeat (3) @(posedge pclk);
        end
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        {rows[0], rows[1], rows[2], rows[3], rows[4]} =
            {4'h4, 4'h3, 4'h6, 4'h7, 4'h1};
        {rows[5], rows[6], rows[7], rows[8]} = {4'h4, 4'h0, 4'hc, 4'he};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`TCW_ADDR_PINS, 32'hff);
        rdchk(`TCW_ADDR_WINDOW, 32'h0);
        rdchk(`TCW_ADDR_CTRL, 32'h0);
        $display("test reset done");
        port_drive_en <= 4'hf;
        // Every compare code on channel 0, interrupts left disabled.
        for (i = 0; i < 9; i = i + 1) begin
            setch(2'd0, {5'h01, rows[i][3:1]}, 16'h1230 + i);
            hit(16'h1230 + i);
            rdchk(`TCW_ADDR_PINS, {28'h0f, 3'h7, rows[i][0]});
            check({31'h0, pin_level[0]}, {31'h0, rows[i][0]});
            rdchk(`TCW_ADDR_FLAGS, 32'h1);
            apb(1'b1, `TCW_ADDR_FLAGS, 32'h1);
            rdchk(`TCW_ADDR_FLAGS, 32'h0);
        end
        $display("test compare codes done");
        setch(2'd1, 8'hda, 16'h0040);
        apb(1'b1, `TCW_ADDR_INDEX, 32'h2);
        rdchk(`TCW_ADDR_WINDOW, 32'h0);
        apb(1'b1, `TCW_ADDR_INDEX, 32'h1);
        rdchk(`TCW_ADDR_WINDOW, 32'h9a);
        // A held equality must clear the timebase only once.
        timer_count <= 16'h0040;
        n = 0;
        repeat (12) begin
            @(negedge pclk);
            n = n + timer_clear;
        end
        @(posedge pclk);
        check(n, 1);
        rdchk(`TCW_ADDR_PINS, 32'hfc);
        check({31'h0, irq_request}, 32'h0);
        apb(1'b1, `TCW_ADDR_CTRL, 32'h1);
        check({31'h0, irq_request}, 32'h1);
        apb(1'b1, `TCW_ADDR_FLAGS, 32'h2);
        check({31'h0, irq_request}, 32'h0);
        $display("test window and interrupt done");
        apb(1'b1, `TCW_ADDR_CTRL, 32'h2);
        rdchk(`TCW_ADDR_PINS, 32'h3c);
        check({28'h0, pin_level}, 32'hc);
        apb(1'b1, `TCW_ADDR_CTRL, 32'h4);
        rdchk(`TCW_ADDR_PINS, 32'h0c);
        hit(16'h0040);
        rdchk(`TCW_ADDR_FLAGS, 32'h2);
        apb(1'b1, `TCW_ADDR_CTRL, 32'h0);
        apb(1'b1, `TCW_ADDR_FLAGS, 32'h2);
        $display("test pin release done");
        // Dual-slope PWM: inverting, then non-inverting, both slopes.
        count_mode_select <= 2'b10;
        setch(2'd0, 8'h0c, 16'h0100);
        for (i = 0; i < 4; i = i + 1) begin
            if (i == 2) begin
                apb(1'b1, `TCW_ADDR_WINDOW, 32'h0d);
            end
            dir = i[0] ^ i[1];
            timer_count_down <= dir;
            hit(16'h0100);
            rdchk(`TCW_ADDR_PINS, {28'h0f, 3'h6, ~i[0]});
            rdchk(`TCW_ADDR_WINDOW, {25'h0, dir, 5'h06, i[1]});
        end
        // Edge-aligned PWM: set on match, cleared at the bottom.
        count_mode_select <= 2'b01;
        timer_count_down <= 1'b0;
        hit(16'h0100);
        rdchk(`TCW_ADDR_PINS, 32'hfd);
        timer_at_bottom <= 1'b1;
        @(posedge pclk);
        timer_at_bottom <= 1'b0;
        repeat (2) @(posedge pclk);
        rdchk(`TCW_ADDR_PINS, 32'hfc);
        $display("test pwm done");
        // Channel 2 captures on comparator A, channel 3 on comparator B.
        setch(2'd2, 8'h06, 16'h0000);
        setch(2'd3, 8'h07, 16'h0000);
        timer_count <= 16'h5a01;
        comparator_a_event <= 1'b1;
        @(posedge pclk);
        comparator_a_event <= 1'b0;
        timer_count <= 16'h6b02;
        comparator_b_event <= 1'b1;
        @(posedge pclk);
        comparator_b_event <= 1'b0;
        @(posedge pclk);
        rdchk(`TCW_ADDR_VALUE_LOW, 32'h02);
        rdchk(`TCW_ADDR_VALUE_HIGH, 32'h6b);
        apb(1'b1, `TCW_ADDR_INDEX, 32'h2);
        rdchk(`TCW_ADDR_VALUE_LOW, 32'h01);
        rdchk(`TCW_ADDR_VALUE_HIGH, 32'h5a);
        $display("test capture done");
        apb(1'b1, 8'h1c, 32'hff);
        rdchk(8'h40, 32'h0);
        check({31'h0, pslverr}, 32'h1);
        rdchk(`TCW_ADDR_CTRL, 32'h0);
        $display("test unmapped done");
        close_out;
    end

    // Cuts a hung run short.
    initial begin
        #900000;
        mismatches = mismatches + 1;
        close_out;
    end
endmodule

bind tcw_top tcw_chk u_tcw_chk (.*);
